/* dea_pkg.sv */
package dea_pkg;

  // ********************************************************
  // special function register map (printed byte offsets)
  // ********************************************************
  localparam logic [7:0] DEA_DATA_OFS = 8'h08;
  localparam logic [7:0] DEA_ADDR_OFS = 8'h09;
  localparam logic [7:0] DEA_CTRL_OFS = 8'h88;
  localparam logic [7:0] DEA_KEY_OFS  = 8'h89;

  // ********************************************************
  // control field positions
  // ********************************************************
  localparam int DEA_RD_BIT    = 0;
  localparam int DEA_WR_BIT    = 1;
  localparam int DEA_PERM_BIT  = 2;
  localparam int DEA_ABORT_BIT = 3;
  localparam int DEA_DONE_BIT  = 4;

  // ********************************************************
  // storage geometry, unlock keys, erased and reset values
  // ********************************************************
  localparam int         DEA_DEPTH    = 64;
  localparam int         DEA_IDX_W    = 6;
  localparam logic [7:0] DEA_KEY_1    = 8'h55;
  localparam logic [7:0] DEA_KEY_2    = 8'hAA;
  localparam logic [7:0] DEA_ERASED   = 8'hFF;
  localparam logic [7:0] DEA_ZERO     = 8'h00;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned DEA_CLK_PERIOD_NS = 8;
  localparam int unsigned DEA_WRITE_TIME_US = 4000;
  localparam int unsigned DEA_WRITE_CYCLES  = (DEA_WRITE_TIME_US * 1000) / DEA_CLK_PERIOD_NS;
  localparam int          DEA_CNT_W         = 20;

  // ********************************************************
  // types
  // ********************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dea_sfr_req_s;

  typedef struct packed {
    logic                 req;
    logic                 we;
    logic [DEA_IDX_W-1:0] addr;
    logic [7:0]           wdata;
  } dea_prog_req_s;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OK   = 2'b10
  } dea_key_e;

  typedef enum logic {
    WS_IDLE = 1'b0,
    WS_BUSY = 1'b1
  } dea_wstate_e;

endpackage

/* dea_data_eeprom_access.sv */
`timescale 1ns/100ps
module dea_data_eeprom_access
  import dea_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = dea_pkg::DEA_WRITE_CYCLES
)
(
  input  wire logic                   clk_i,          // instruction clock
  input  wire logic                   srst_i,         // sync reset, any cause
  input  wire logic                   por_i,          // reset is power-on
  input  wire dea_pkg::dea_sfr_req_s  sfr_i,          // cpu register access
  output logic [7:0]                  sfr_rdata_o,    // register read data
  input  wire logic                   code_protect_i, // code protection on
  input  wire dea_pkg::dea_prog_req_s prog_i,         // programmer access
  output logic [7:0]                  prog_rdata_o    // programmer read data
);
  import dea_pkg::*;

  initial
  begin
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << DEA_CNT_W))
      $error("WRITE_CYCLES out of range");
  end

  // ********************************************************
  // register state
  // ********************************************************
  logic [7:0]           storage_data_reg;
  logic [7:0]           storage_address_reg;
  logic                 write_done_flag;
  logic                 write_abort_flag;
  logic                 write_permit;
  logic                 rd_pend;
  dea_wstate_e          wstate;
  dea_key_e             key;
  logic [DEA_CNT_W-1:0] wcnt;
  logic [DEA_IDX_W-1:0] w_idx;
  logic                 w_hit;
  logic [7:0]           w_data;
  logic [7:0]           mem [DEA_DEPTH];

  localparam logic [DEA_CNT_W-1:0] W_LAST = DEA_CNT_W'(WRITE_CYCLES - 1);

  logic sel_data;
  logic sel_addr;
  logic sel_ctrl;
  logic sel_key;
  logic wr_try;
  logic wr_start;
  logic wr_end;
  logic busy;
  logic a_hit;
  logic prog_ok;
  logic [7:0] ctrl_view;
  logic [7:0] next_rdata;

  assign sel_data = sfr_i.wr && (sfr_i.addr == DEA_DATA_OFS);
  assign sel_addr = sfr_i.wr && (sfr_i.addr == DEA_ADDR_OFS);
  assign sel_ctrl = sfr_i.wr && (sfr_i.addr == DEA_CTRL_OFS);
  assign sel_key  = sfr_i.wr && (sfr_i.addr == DEA_KEY_OFS);
  assign busy     = (wstate == WS_BUSY);
  // upper two address bits must be zero for a real location
  assign a_hit    = (storage_address_reg[7:6] == 2'b00);
  assign wr_try   = sel_ctrl && sfr_i.wdata[DEA_WR_BIT];
  assign wr_start = wr_try && write_permit && (key == KEY_OK) && !busy;
  assign wr_end   = busy && (wcnt == W_LAST);
  assign prog_ok  = prog_i.req && !code_protect_i && !busy;
  assign ctrl_view = {3'b000, write_done_flag, write_abort_flag, write_permit,
                      busy, rd_pend};

  // ********************************************************
  // unlock sequence
  // ********************************************************
  // any other register write breaks the sequence
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      key <= KEY_IDLE;
    else if (sel_key && sfr_i.wdata == DEA_KEY_1)
      key <= KEY_HALF;
    else if (sel_key && sfr_i.wdata == DEA_KEY_2 && key == KEY_HALF)
      key <= KEY_OK;
    else if (sfr_i.wr)
      key <= KEY_IDLE;
  end

  // ********************************************************
  // write engine
  // ********************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wstate <= WS_IDLE;
      wcnt   <= '0;
    end
    else if (wr_start)
    begin
      wstate <= WS_BUSY;
      wcnt   <= '0;
    end
    else if (wr_end)
      wstate <= WS_IDLE;
    else if (busy)
      wcnt <= wcnt + 1'b1;
  end

  // latched target so later register writes cannot disturb it
  always_ff @(posedge clk_i)
  begin
    if (wr_start)
    begin
      w_idx  <= storage_address_reg[DEA_IDX_W-1:0];
      w_hit  <= a_hit;
      w_data <= storage_data_reg;
    end
  end

  // ********************************************************
  // storage array
  // ********************************************************
  // nonvolatile: no reset; interrupted write leaves cell erased
  for (genvar i = 0; i < DEA_DEPTH; i++)
  begin : g_cell
    always_ff @(posedge clk_i)
    begin
      if (!srst_i && wr_start && a_hit
          && storage_address_reg[DEA_IDX_W-1:0] == DEA_IDX_W'(i))
        mem[i] <= DEA_ERASED;
      else if (!srst_i && wr_end && w_hit && w_idx == DEA_IDX_W'(i))
        mem[i] <= w_data;
      else if (prog_ok && prog_i.we && prog_i.addr == DEA_IDX_W'(i))
        mem[i] <= prog_i.wdata;
    end
  end

  // ********************************************************
  // control flags
  // ********************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      write_permit    <= 1'b0;
      write_done_flag <= 1'b0;
    end
    else
    begin
      if (sel_ctrl)
        write_permit <= sfr_i.wdata[DEA_PERM_BIT];
      // completion beats a same-cycle software clear
      if (wr_end)
        write_done_flag <= 1'b1;
      else if (sel_ctrl)
        write_done_flag <= sfr_i.wdata[DEA_DONE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i && por_i)
      write_abort_flag <= 1'b0;
    else if (srst_i && busy)
      write_abort_flag <= 1'b1;
    else if (!srst_i && sel_ctrl)
      write_abort_flag <= sfr_i.wdata[DEA_ABORT_BIT];
  end

  // ********************************************************
  // read engine, data and address registers
  // ********************************************************
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rd_pend <= 1'b0;
    else if (rd_pend)
      rd_pend <= 1'b0;
    else if (sel_ctrl && sfr_i.wdata[DEA_RD_BIT])
      rd_pend <= 1'b1;
  end

  // data and address survive non power-on resets
  always_ff @(posedge clk_i)
  begin
    if (srst_i && por_i)
      storage_data_reg <= DEA_ZERO;
    else if (!srst_i && rd_pend)
      storage_data_reg <= a_hit ? mem[storage_address_reg[DEA_IDX_W-1:0]]
                                : DEA_ZERO;
    else if (!srst_i && sel_data)
      storage_data_reg <= sfr_i.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i && por_i)
      storage_address_reg <= DEA_ZERO;
    else if (!srst_i && sel_addr)
      storage_address_reg <= sfr_i.wdata;
  end

  // ********************************************************
  // read ports
  // ********************************************************
  always_comb
  begin
    case (sfr_i.addr)
      DEA_DATA_OFS: next_rdata = storage_data_reg;
      DEA_ADDR_OFS: next_rdata = storage_address_reg;
      DEA_CTRL_OFS: next_rdata = ctrl_view;
      default:      next_rdata = DEA_ZERO; // key register reads zero
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      sfr_rdata_o <= DEA_ZERO;
    else if (sfr_i.rd)
      sfr_rdata_o <= next_rdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      prog_rdata_o <= DEA_ZERO;
    else if (prog_i.req)
      prog_rdata_o <= prog_ok ? mem[prog_i.addr] : DEA_ZERO;
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_start_needs_key: assert property (wr_start |-> key == KEY_OK ##1 key == KEY_IDLE)
    else $error("write started without unlock keys");
  a_start_needs_permit: assert property (
    $rose(busy) |-> $past(write_permit))
    else $error("write started without permit");
  a_write_duration: assert property (
    $fell(busy) |-> $past(wcnt) == W_LAST)
    else $error("write duration wrong");
  a_done_on_end: assert property (wr_end |=> write_done_flag && !busy)
    else $error("done flag not set at write end");
  a_read_one_cycle: assert property (
    $rose(rd_pend) |=> !rd_pend && storage_data_reg ==
      (a_hit ? mem[storage_address_reg[DEA_IDX_W-1:0]] : DEA_ZERO))
    else $error("read did not complete in one cycle");
  a_data_held: assert property (
    !rd_pend && !sel_data |=> $stable(storage_data_reg))
    else $error("data register changed without cause");
  a_ctrl_upper_zero: assert property (
    $past(sfr_i.rd) && $past(sfr_i.addr) == DEA_CTRL_OFS
      |-> sfr_rdata_o[7:5] == 3'b000)
    else $error("control upper bits not zero");
  a_busy_target_stable: assert property (
    busy && $past(busy) |-> $stable(w_idx) && $stable(w_data))
    else $error("write target changed during write");
  a_prog_blocked: assert property (
    prog_i.req && code_protect_i |=> prog_rdata_o == DEA_ZERO)
    else $error("programmer read while protected");
  a_wr_clear_ignored: assert property (
    busy && sel_ctrl && !sfr_i.wdata[DEA_WR_BIT] && !wr_end |=> busy)
    else $error("software cleared write bit");

  c_full_write: cover property (wr_end ##1 write_done_flag);
  c_read: cover property ($rose(rd_pend));
  c_refused_start: cover property (wr_try && !wr_start);
  c_prog_blocked: cover property (prog_i.req && code_protect_i);

endmodule

/* tb.sv */
`timescale 1ns/100ps
module tb;
  import dea_pkg::*;
  localparam int WC = 20;
  logic          clk_i = 1'b0;
  logic          srst_i = 1'b1;
  logic          por_i = 1'b1;
  logic          code_protect_i = 1'b0;
  dea_sfr_req_s  sfr_i = '0;
  dea_prog_req_s prog_i = '0;
  logic [7:0]    sfr_rdata_o;
  logic [7:0]    prog_rdata_o;
  logic [7:0]    v;
  logic [7:0]    a;
  logic [7:0]    d;
  int            miscompares = 0;
  int            tests_run = 0;
  int            cyc = 0;

  // short write time keeps the run small; expectations follow WC
  dea_data_eeprom_access #(.WRITE_CYCLES(WC)) dea_data_eeprom_access_i (
    .clk_i          (clk_i),
    .srst_i         (srst_i),
    .por_i          (por_i),
    .sfr_i          (sfr_i),
    .sfr_rdata_o    (sfr_rdata_o),
    .code_protect_i (code_protect_i),
    .prog_i         (prog_i),
    .prog_rdata_o   (prog_rdata_o)
  );

  initial
  begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  // expected control byte built from the field positions
  function automatic logic [7:0] ctrl_exp(input logic done, input logic abort,
                                          input logic perm, input logic wr);
    logic [7:0] c;
    c = 8'h00;
    c[DEA_DONE_BIT]  = done;
    c[DEA_ABORT_BIT] = abort;
    c[DEA_PERM_BIT]  = perm;
    c[DEA_WR_BIT]    = wr;
    return c;
  endfunction

  // locations above the implemented space read as zero
  function automatic logic [7:0] loc_exp(input logic [7:0] ad, input logic [7:0] stored);
    return (ad[7:6] == 2'b00) ? stored : 8'h00;
  endfunction

  // one register access; always leaves an idle cycle behind it
  task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clk_i);
    sfr_i = '{wr: w, rd: !w, addr: ad, wdata: dt};
    @(negedge clk_i);
    v = sfr_rdata_o;
    sfr_i = '0;
  endtask

  task automatic prog(input logic w, input logic [5:0] ad, input logic [7:0] dt);
    @(negedge clk_i);
    prog_i = '{req: 1'b1, we: w, addr: ad, wdata: dt};
    @(negedge clk_i);
    v = prog_rdata_o;
    prog_i = '0;
  endtask

  task automatic keys(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] p);
    acc(1'b1, DEA_KEY_OFS, k1);
    acc(1'b1, DEA_KEY_OFS, k2);
    acc(1'b1, DEA_CTRL_OFS, p | 8'h02);
  endtask

  task automatic start(input logic [7:0] ad, input logic [7:0] dt);
    acc(1'b1, DEA_DATA_OFS, dt);
    acc(1'b1, DEA_ADDR_OFS, ad);
    acc(1'b1, DEA_CTRL_OFS, 8'h04);
    keys(DEA_KEY_1, DEA_KEY_2, 8'h04);
  endtask

  task automatic wait_done;
    for (int i = 0; i < 60; i++)
    begin
      acc(1'b0, DEA_CTRL_OFS, 8'h00);
      if (v[DEA_DONE_BIT] === 1'b1)
        break;
    end
    acc(1'b0, DEA_CTRL_OFS, 8'h00);
    chk("ctrl after write", v, ctrl_exp(1'b1, 1'b0, 1'b1, 1'b0));
    acc(1'b1, DEA_CTRL_OFS, 8'h00);
  endtask

  task automatic read_loc(input logic [7:0] ad);
    acc(1'b1, DEA_ADDR_OFS, ad);
    acc(1'b1, DEA_CTRL_OFS, 8'h01);
    @(negedge clk_i);
    acc(1'b0, DEA_DATA_OFS, 8'h00);
  endtask

  initial
  begin
    void'($urandom(58));
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    acc(1'b0, DEA_CTRL_OFS, 8'h00);
    chk("ctrl at power-on", v, 8'h00);
    acc(1'b0, DEA_ADDR_OFS, 8'h00);
    chk("addr at power-on", v, 8'h00);
    acc(1'b1, 8'h10, 8'h55);
    acc(1'b0, 8'h10, 8'h00);
    chk("unmapped read", v, 8'h00);
    acc(1'b0, DEA_KEY_OFS, 8'h00);
    chk("key read", v, 8'h00);
    acc(1'b1, DEA_CTRL_OFS, 8'hE0);
    acc(1'b0, DEA_CTRL_OFS, 8'h00);
    chk("ctrl upper bits", v, 8'h00);
    $display("test reset and map done");
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h3F : 8'($urandom_range(63));
      d = 8'($urandom);
      start(a, d);
      acc(1'b0, DEA_CTRL_OFS, 8'h00);
      chk("ctrl busy", v, ctrl_exp(1'b0, 1'b0, 1'b1, 1'b1));
      wait_done();
      read_loc(a);
      chk("read back", v, loc_exp(a, d));
    end
    $display("test random writes done");
    acc(1'b1, DEA_DATA_OFS, ~d);
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, DEA_CTRL_OFS, (i == 0) ? 8'h00 : 8'h04);
      if (i == 0) keys(DEA_KEY_1, DEA_KEY_2, 8'h00);
      else if (i == 1) keys(DEA_KEY_2, DEA_KEY_1, 8'h04);
      else keys(DEA_KEY_1, DEA_KEY_1, 8'h04);
      acc(1'b0, DEA_CTRL_OFS, 8'h00);
      chk("refused start", v, ctrl_exp(1'b0, 1'b0, i != 0, 1'b0));
    end
    repeat (WC + 4) @(negedge clk_i);
    read_loc(a);
    chk("location untouched", v, d);
    $display("test refused starts done");
    start(8'h05, 8'h3C);
    acc(1'b1, DEA_CTRL_OFS, 8'h00);
    acc(1'b1, DEA_CTRL_OFS, 8'h04);
    keys(DEA_KEY_1, DEA_KEY_2, 8'h04);
    prog(1'b1, 6'h05, 8'hC3);
    wait_done();
    read_loc(8'h05);
    chk("busy write kept", v, 8'h3C);
    start(8'h45, 8'h12);
    wait_done();
    read_loc(8'h05);
    chk("high addr write", v, 8'h3C);
    read_loc(8'hC5);
    chk("high addr read", v, loc_exp(8'hC5, 8'h3C));
    $display("test busy and high address done");
    prog(1'b1, 6'h07, 8'h5A);
    read_loc(8'h07);
    chk("programmer write", v, 8'h5A);
    code_protect_i = 1'b1;
    prog(1'b0, 6'h07, 8'h00);
    chk("protected read", v, 8'h00);
    prog(1'b1, 6'h07, 8'hA5);
    start(8'h08, 8'h77);
    wait_done();
    read_loc(8'h07);
    chk("protected write", v, 8'h5A);
    read_loc(8'h08);
    chk("cpu under protect", v, 8'h77);
    code_protect_i = 1'b0;
    prog(1'b0, 6'h08, 8'h00);
    chk("programmer read", v, 8'h77);
    $display("test code protection done");
    start(8'h09, 8'h61);
    repeat (3) @(negedge clk_i);
    por_i = 1'b0;
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    acc(1'b0, DEA_CTRL_OFS, 8'h00);
    chk("ctrl after abort", v, ctrl_exp(1'b0, 1'b1, 1'b0, 1'b0));
    acc(1'b0, DEA_DATA_OFS, 8'h00);
    chk("data kept", v, 8'h61);
    acc(1'b0, DEA_ADDR_OFS, 8'h00);
    chk("addr kept", v, 8'h09);
    read_loc(8'h09);
    chk("erased location", v, DEA_ERASED);
    $display("test abort by reset done");
    give_verdict();
  end
endmodule
